// [rtl/fuser_age_timer.sv]
/*
 cycle down-counter with load and expiry flag.
 assumes a synchronous active-low reset.
*/
module fuser_age_timer (
	// clock and reset
	input  wire logic                                i_core_clk,
	input  wire logic                                i_rst_n,
	// control
	input  wire logic                                i_load,
	input  wire logic [fuser_age_pkg::CNT_W-1:0]     i_count,
	// status
	output logic                                     o_expired
);
	logic [fuser_age_pkg::CNT_W-1:0] cnt_q;
	localparam logic [fuser_age_pkg::CNT_W-1:0] LAST_TICK =
		{{(fuser_age_pkg::CNT_W-1){1'b0}}, 1'b1};

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else if (i_load) begin
			cnt_q <= i_count;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_expired <= 1'b0;
		end else begin
			o_expired <= !i_load && (cnt_q == LAST_TICK);
		end
	end
endmodule

// [rtl/fuser_unit_age_detect.sv]
/*
 fuser unit age detection: senses the unit fuse, blows it on a new unit,
 clears the fuser life counters and flags a fuse that will not blow.
 assumes synchronous inputs and a controller that acts on the clear pulse.
*/
// Functional notes
// - unit_age_sense high means a used unit, low means a new unit.
// - a new unit activates the fuse burn drive and clears life counters.
// - fuse_burn_drive is low to blow the fuse and high at all other times.
// - cover_supply_sense high means cover closed, low means cover opened.
// - fault C4C0 is raised when a new unit was judged but the fuse held.
// - the fuse blowing clears counters 08-1250/1270/1272/1274/1276.
// - clearing only when setting 08-4549 is 0, latched at power-up.
module fuser_unit_age_detect (
	// clock and reset
	input  wire logic                              i_core_clk,
	input  wire logic                              i_rst_n,
	// fuser unit pins
	input  wire logic                              i_unit_age_sense,
	input  wire logic                              i_cover_supply_sense,
	output logic                                   o_fuse_burn_drive,
	// controller side
	input  wire logic                              i_clear_inhibit,
	output logic                                   o_cover_closed,
	output logic                                   o_unit_new,
	output logic [fuser_age_pkg::NUM_LIFE-1:0]     o_life_clear,
	output logic                                   o_fault,
	output logic [15:0]                            o_fault_code
);
	fuser_age_pkg::age_state_e state_q;
	logic                      inhibit_q;
	logic                      inhibit_taken_q;
	logic                      tmr_load;
	logic [fuser_age_pkg::CNT_W-1:0] tmr_count;
	logic                      tmr_expired;
	logic                      cover_closed;
	logic                      sense_used;
	logic                      burn_on;
	logic                      clear_fire;

	// state decode shared by the drive, clear and fault flops
	function automatic logic at_state(
		input fuser_age_pkg::age_state_e st,
		input fuser_age_pkg::age_state_e want
	);
		return st == want;
	endfunction

	// a verdict needs the settle run out with the cover still shut
	function automatic logic judge_now(
		input fuser_age_pkg::age_state_e st,
		input logic                      expired,
		input logic                      closed
	);
		return (st == fuser_age_pkg::ST_SETTLE) && expired && closed;
	endfunction

	assign cover_closed = i_cover_supply_sense;
	assign sense_used   = i_unit_age_sense;

	// setting is caught once after reset; later changes wait for power cycle
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			inhibit_taken_q <= 1'b0;
		end else begin
			inhibit_taken_q <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			inhibit_q <= fuser_age_pkg::INHIBIT_ON;
		end else if (!inhibit_taken_q) begin
			inhibit_q <= i_clear_inhibit;
		end
	end

	always_comb begin
		tmr_load  = 1'b0;
		tmr_count = '0;
		case (state_q)
			fuser_age_pkg::ST_WAIT_COVER: begin
				tmr_load  = cover_closed;
				tmr_count = fuser_age_pkg::CNT_W'(fuser_age_pkg::SETTLE_CYC);
			end
			fuser_age_pkg::ST_SETTLE: begin
				tmr_load  = judge_now(state_q, tmr_expired, cover_closed)
				            && !sense_used;
				tmr_count = fuser_age_pkg::CNT_W'(fuser_age_pkg::BURN_MAX_CYC);
			end
			// the burn limit runs from the verdict edge; nothing reloads it
			fuser_age_pkg::ST_BURN: begin
				tmr_load  = 1'b0;
				tmr_count = '0;
			end
			fuser_age_pkg::ST_DONE: begin
				tmr_load  = 1'b0;
				tmr_count = '0;
			end
			fuser_age_pkg::ST_FAULT: begin
				tmr_load  = 1'b0;
				tmr_count = '0;
			end
			default: begin
				tmr_load  = 1'b0;
				tmr_count = '0;
			end
		endcase
	end

	// one shared timer: settle and burn limit never run at once
	fuser_age_timer u_timer (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_load     (tmr_load),
		.i_count    (tmr_count),
		.o_expired  (tmr_expired)
	);

	// decision only with the cover closed: 24 V must be present to sense
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_q <= fuser_age_pkg::ST_WAIT_COVER;
		end else begin
			case (state_q)
				fuser_age_pkg::ST_WAIT_COVER: begin
					if (cover_closed && inhibit_taken_q) begin
						state_q <= fuser_age_pkg::ST_SETTLE;
					end
				end
				fuser_age_pkg::ST_SETTLE: begin
					if (!cover_closed) begin
						state_q <= fuser_age_pkg::ST_WAIT_COVER;
					end else if (tmr_expired) begin
						state_q <= sense_used ? fuser_age_pkg::ST_DONE
						                      : fuser_age_pkg::ST_BURN;
					end
				end
				fuser_age_pkg::ST_BURN: begin
					if (sense_used) begin
						state_q <= fuser_age_pkg::ST_DONE;
					end else if (tmr_expired || !cover_closed) begin
						state_q <= fuser_age_pkg::ST_FAULT;
					end
				end
				fuser_age_pkg::ST_DONE: begin
					if (!cover_closed) begin
						state_q <= fuser_age_pkg::ST_WAIT_COVER;
					end
				end
				fuser_age_pkg::ST_FAULT: begin
					state_q <= fuser_age_pkg::ST_FAULT;
				end
				default: begin
					state_q <= fuser_age_pkg::ST_WAIT_COVER;
				end
			endcase
		end
	end

	// active low drive, held off outside the burn state
	assign burn_on = at_state(state_q, fuser_age_pkg::ST_BURN)
	                 && !sense_used && !tmr_expired && cover_closed;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_fuse_burn_drive <= 1'b1;
		end else begin
			o_fuse_burn_drive <= !burn_on;
		end
	end

	// one-cycle clear pulse for all five counters when the fuse gives way
	assign clear_fire = at_state(state_q, fuser_age_pkg::ST_BURN)
	                    && sense_used
	                    && (inhibit_q != fuser_age_pkg::INHIBIT_ON);

	// one flop per counter, all fed by the same event so they pulse together
	for (genvar g = 0; g < fuser_age_pkg::NUM_LIFE; g++) begin : g_life
		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n) begin
				o_life_clear[g] <= 1'b0;
			end else begin
				o_life_clear[g] <= clear_fire;
			end
		end
	end

	// sticky until reset so a controller polling late still sees it
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_fault <= 1'b0;
		end else if (at_state(state_q, fuser_age_pkg::ST_FAULT)) begin
			o_fault <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_fault_code <= fuser_age_pkg::FAULT_NONE;
		end else if (at_state(state_q, fuser_age_pkg::ST_FAULT)) begin
			o_fault_code <= fuser_age_pkg::FAULT_FUSE_INTACT;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_cover_closed <= 1'b0;
		end else begin
			o_cover_closed <= cover_closed;
		end
	end

	// unit_new keeps the last verdict; a cover opened at expiry gives none
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_unit_new <= 1'b0;
		end else if (judge_now(state_q, tmr_expired, cover_closed)) begin
			o_unit_new <= !sense_used;
		end
	end
endmodule

// [shared/fuser_age_pkg.sv]
/*
 fuser unit age detection constants: timing, counter identities, fault code.
 assumes a 40 MHz core clock.
*/
package fuser_age_pkg;
	localparam int unsigned CLK_HZ          = 40_000_000;
	// sense settle time before a new/used decision, in microseconds
	localparam int unsigned SETTLE_US       = 1000;
	localparam int unsigned SETTLE_CYC      = SETTLE_US * (CLK_HZ / 1_000_000);
	// longest burn drive before giving up, in milliseconds
	localparam int unsigned BURN_MAX_MS     = 500;
	localparam int unsigned BURN_MAX_CYC    = BURN_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned CNT_W           = 25;
	localparam int unsigned NUM_LIFE        = 5;
	// life counter setting codes, index order of the clear mask
	localparam logic [15:0] LIFE_CODE [NUM_LIFE] = '{
		16'h1250, 16'h1270, 16'h1272, 16'h1274, 16'h1276};
	localparam logic [15:0] FAULT_FUSE_INTACT = 16'hC4C0;
	localparam logic [15:0] FAULT_NONE        = 16'h0000;
	localparam logic        INHIBIT_ON        = 1'b1;

	typedef enum logic [4:0] {
		ST_WAIT_COVER = 5'b00001,
		ST_SETTLE     = 5'b00010,
		ST_BURN       = 5'b00100,
		ST_DONE       = 5'b01000,
		ST_FAULT      = 5'b10000
	} age_state_e;
endpackage

// [tb/fuse_model.sv]
/*
 fuser unit fuse: blows after a run of active-low drive unless stuck.
 assumes i_fresh restores an intact fuse.
*/
module fuse_model #(parameter int BLOW = 20) (
	input  wire logic i_clk,
	input  wire logic i_fresh,
	input  wire logic i_stuck,
	input  wire logic i_drive_n,
	output logic      o_sense
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	always_ff @(posedge i_clk) begin
		if (i_fresh) n <= 0;
		else if (!i_drive_n && !i_stuck && n < BLOW) n <= n + 1;
	end
	assign o_sense = (n >= BLOW);
endmodule

// [tb/fuser_age_checker.sv]
/*
 port assertions for the fuser unit age block.
 assumes it is bound onto the top module.
*/
module fuser_age_checker (
	input wire logic                          i_core_clk,
	input wire logic                          i_rst_n,
	input wire logic                          i_unit_age_sense,
	input wire logic                          i_cover_supply_sense,
	input wire logic                          o_fuse_burn_drive,
	input wire logic                          o_cover_closed,
	input wire logic                          o_unit_new,
	input wire logic [fuser_age_pkg::NUM_LIFE-1:0] o_life_clear,
	input wire logic                          o_fault,
	input wire logic [15:0]                   o_fault_code,
	input wire logic                          i_clear_inhibit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic armed_q;
	logic inhibit_seen_q;

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// the setting counts as read once, at the first edge out of reset
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			armed_q        <= 1'b0;
			inhibit_seen_q <= 1'b1;
		end else if (!armed_q) begin
			armed_q        <= 1'b1;
			inhibit_seen_q <= i_clear_inhibit;
		end
	end
	a_cover_copy: assert property (
		$rose(i_cover_supply_sense) |=> o_cover_closed) else $error("cover");
	a_clear_all: assert property (
		o_life_clear != 0 |-> o_life_clear == 5'h1F) else $error("clear mask");
	a_clear_pulse: assert property (
		o_life_clear != 0 |=> o_life_clear == 0) else $error("clear width");
	a_fault_code: assert property (
		o_fault_code == (o_fault ? 16'hC4C0 : 16'h0000)) else $error("code");
	a_fault_sticky: assert property (
		o_fault |=> o_fault) else $error("fault dropped");
	a_burn_release: assert property (
		!o_fuse_burn_drive && i_unit_age_sense |=> o_fuse_burn_drive)
		else $error("burn held");
	a_open_fault: assert property (
		!o_fuse_burn_drive && !i_cover_supply_sense && !i_unit_age_sense
		|-> ##[1:3] (o_fault && o_fuse_burn_drive)) else $error("open burn");
	a_burn_new: assert property (
		$fell(o_fuse_burn_drive) |-> o_unit_new && o_cover_closed)
		else $error("burn cause");
	a_clear_inhibit: assert property (
		inhibit_seen_q |-> o_life_clear == 0) else $error("clear inhibited");
endmodule

bind fuser_unit_age_detect fuser_age_checker fuser_age_checker_i (
	.i_core_clk, .i_rst_n, .i_unit_age_sense, .i_cover_supply_sense,
	.o_fuse_burn_drive, .o_cover_closed, .o_unit_new, .o_life_clear,
	.o_fault, .o_fault_code, .i_clear_inhibit);

// [tb/tb.sv]
/*
 testbench: cover rows, new unit clear, stuck fuse fault.
 assumes settle and burn limits of the package.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, cov = 0, inh = 0, fresh = 1, stuck = 0;
	logic sense, drive, cc, unew, flt;
	logic [4:0] clr;
	logic [15:0] code;
	int err_count = 0, num_checks = 0, k;
	logic [1:0] rows [4] = '{2'b11, 2'b00, 2'b11, 2'b00};
	initial forever #12.5 clk = ~clk;
	fuse_model fuse_model_i (.i_clk(clk), .i_fresh(fresh), .i_stuck(stuck),
		.i_drive_n(drive), .o_sense(sense));
	fuser_unit_age_detect fuser_unit_age_detect_i (.i_core_clk(clk),
		.i_rst_n(rst_n), .i_unit_age_sense(sense),
		.i_cover_supply_sense(cov), .o_fuse_burn_drive(drive),
		.i_clear_inhibit(inh), .o_cover_closed(cc), .o_unit_new(unew),
		.o_life_clear(clr), .o_fault(flt), .o_fault_code(code));
	task automatic chk(input string n, input logic [15:0] e, s);
		num_checks++;
		if (e !== s) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic hold(input int c);
		repeat (c) @(negedge clk);
	endtask
	initial begin
		hold(12);
		rst_n = 1;
		fresh = 0;
		foreach (rows[i]) begin
			cov = rows[i][1];
			hold(2);
			chk("cover", rows[i][0], cc);
		end
		$display("rows done");
		// a late change of the setting must not reach the latched copy
		inh = 1;
		cov = 1;
		// settle alone is 40000 cycles, so only one decision fits the run
		for (k = 0; k < 45000 && clr === 5'h00; k++) hold(1);
		chk("clear wait", 1'b1, k < 45000);
		chk("clear", 5'h1F, clr);
		chk("new", 1'b1, unew);
		chk("drive off", 1'b1, drive);
		hold(1);
		chk("clear pulse", 5'h00, clr);
		$display("new unit done");
		rst_n = 0;
		fresh = 1;
		stuck = 1;
		cov = 0;
		hold(12);
		chk("rst drive", 1'b1, drive);
		chk("rst fault", 1'b0, flt);
		chk("rst code", 16'h0000, code);
		chk("rst new", 1'b0, unew);
		chk("rst clear", 5'h00, clr);
		chk("rst cover", 1'b0, cc);
		rst_n = 1;
		fresh = 0;
		hold(2);
		cov = 1;
		for (k = 0; k < 45000 && drive !== 1'b0; k++) hold(1);
		chk("burn wait", 1'b1, k < 45000);
		chk("new", 1'b1, unew);
		hold(30);
		chk("burn on", 1'b0, drive);
		cov = 0;
		hold(4);
		chk("fault", 1'b1, flt);
		chk("code", 16'hC4C0, code);
		chk("drive off", 1'b1, drive);
		$display("stuck fuse done");
		summarize;
	end
endmodule
